// ===== verilog/atr_pkg.sv
// Package: constants, field layout and types of the converter trigger/reset/monitor block
// Functional notes
// [R01] Bit 7 picks priority start: pin or timer5
// [R02] Bit 6 gates hardware priority starts
// [R03] Bit 5 picks normal start: pin or timer6
// [R04] Bit 4 gates hardware normal starts
// [R05] Writing key 10 then 01 soft-resets converter
// [R06] Soft reset clears all except conversion clock
// [R07] Software avoids shared external trigger conflict
// [R08] Source bits held at 1; writes of 0 refused
// [R09] Direction bit: 0 below, 1 above compare
// [R10] Source code 0-7 normal, 1xxx priority result
// [R11] Enable bit switches compare and interrupt on; here it gates the compare, irq also needs OFS_IRQ_EN bit 0
// [R12] Reading priority control clears done flag
// [R13] Done flag bit 7, set on completion
// [R14] Disabled trigger events ignored, not remembered
package atr_pkg;
  localparam int ADDR_W = 8;
  localparam int RES_W = 10;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MON0_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG_RST = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP0 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CLK_SET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h1c;
  // Field positions
  localparam int B_PRIO_SRC = 7;
  localparam int B_PRIO_EN = 6;
  localparam int B_NORM_SRC = 5;
  localparam int B_NORM_EN = 4;
  localparam int B_MON_DIR = 5;
  localparam int B_MON_SRC_LO = 1;
  localparam int B_MON_EN = 0;
  localparam int B_DONE = 7;
  localparam int N_IRQ = 2;
  localparam int I_MON0 = 0;
  localparam int I_PRIO_DONE = 1;
  localparam logic [1:0] KEY_ARM = 2'h2;
  localparam logic [1:0] KEY_FIRE = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CLK_SET_RST = 4'h0;
  // Trigger and monitor configuration carriers, key state
  typedef struct packed {
    logic prio_src;
    logic prio_en;
    logic norm_src;
    logic norm_en;
  } atr_trig_cfg_t;
  typedef struct packed {
    logic dir;
    logic [3:0] src;
    logic en;
  } atr_mon_cfg_t;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01
  } atr_key_state_t;
endpackage

// ===== verilog/atr_monitor.sv
// Result monitor: picks a result and compares it against a value
`timescale 1ns/1ps
`default_nettype none
module atr_monitor
  import atr_pkg::*;
#(
  parameter int NRES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic srst_in,
  input wire atr_mon_cfg_t cfg_in,
  input wire logic [NRES*RES_W-1:0] norm_res_in,
  input wire logic [RES_W-1:0] prio_res_in,
  input wire logic [RES_W-1:0] cmp_in,
  output logic hit_out
);
  logic [RES_W-1:0] sel;
  logic hit_q;
  // Source select: high code bit picks priority result
  always_comb begin
    if (cfg_in.src[3]) begin // R10
      sel = prio_res_in;
    end else begin
      sel = norm_res_in[cfg_in.src[2:0]*RES_W +: RES_W]; // R10
    end
  end
  // Registered compare, enabled only by the monitor enable
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hit_q <= 1'b0;
    end else if (srst_in || !cfg_in.en) begin // R11
      hit_q <= 1'b0;
    end else begin
      hit_q <= cfg_in.dir ? (sel > cmp_in) : (sel < cmp_in); // R09
    end
  end
  assign hit_out = hit_q;
  a_mon_off_quiet: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R11
    !cfg_in.en |=> !hit_q) else $error("monitor hit while disabled");
endmodule // atr_monitor
`default_nettype wire

// ===== verilog/atr_ctrl.sv
// Top: trigger selection, soft reset key, monitor 0 config and AXI4-Lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module atr_ctrl
  import atr_pkg::*;
#(
  parameter int NRES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trig_in,
  input wire logic timer5_compare0_in,
  input wire logic timer6_compare0_in,
  input wire logic prio_conv_done_in,
  input wire logic [NRES*RES_W-1:0] norm_res_in,
  input wire logic [RES_W-1:0] prio_res_in,
  output logic prio_hw_start_out,
  output logic norm_hw_start_out,
  output logic soft_reset_out,
  output logic [3:0] conversion_clock_setting_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic wstrb0_q; // Byte 0 strobe taken together with the data
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_go;
  atr_trig_cfg_t trig_q;
  atr_mon_cfg_t mon_q;
  atr_key_state_t key_q;
  logic [RES_W-1:0] cmp_q;
  logic [3:0] clk_set_q;
  logic done_q, srst_q, mon_hit;
  logic [N_IRQ-1:0] stat_q, en_q, ev;
  logic [2:0] ext_s_q, t5_s_q, t6_s_q, dn_s_q;
  logic ext_r, t5_r, t6_r, dn_r;

  function automatic logic wsel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return (a == o) && wstrb0_q;
  endfunction

  // Write address and data may arrive in either order
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

  // Write response
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      if (awaddr_q == OFS_PRIO_CTRL || awaddr_q == OFS_MON0_CTRL || awaddr_q == OFS_TRIG_RST ||
          awaddr_q == OFS_CMP0 || awaddr_q == OFS_CLK_SET || awaddr_q == OFS_IRQ_STAT ||
          awaddr_q == OFS_IRQ_EN || awaddr_q == OFS_IRQ_CLR) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // Register write side
  // ----------------------------------------------------------------
  // Trigger config; source bits stay at timer match
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_q <= '{prio_src: 1'b1, prio_en: 1'b0, norm_src: 1'b1, norm_en: 1'b0}; // R08
    end else if (srst_q) begin
      trig_q <= '{prio_src: 1'b1, prio_en: 1'b0, norm_src: 1'b1, norm_en: 1'b0}; // R06 R08
    end else if (wr_go && wsel(awaddr_q, OFS_TRIG_RST)) begin
      trig_q.prio_src <= 1'b1; // R08
      trig_q.norm_src <= 1'b1; // R08
      trig_q.prio_en <= wdata_q[B_PRIO_EN];
      trig_q.norm_en <= wdata_q[B_NORM_EN];
    end
  end

  // Soft reset key: 10 arms, a following 01 fires
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key_q <= KEY_IDLE;
      srst_q <= 1'b0;
    end else begin
      srst_q <= 1'b0;
      if (wr_go && wsel(awaddr_q, OFS_TRIG_RST)) begin
        case (key_q)
          KEY_IDLE: begin
            key_q <= (wdata_q[1:0] == KEY_ARM) ? KEY_ARMED : KEY_IDLE; // R05
          end
          KEY_ARMED: begin
            if (wdata_q[1:0] == KEY_FIRE) begin
              srst_q <= 1'b1; // R05
              key_q <= KEY_IDLE;
            end else begin
              key_q <= (wdata_q[1:0] == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            end
          end
          default: key_q <= KEY_IDLE;
        endcase
      end
    end
  end
  assign soft_reset_out = srst_q;

  // Monitor config, compare value, irq enable
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mon_q <= '0;
      cmp_q <= '0;
      en_q <= '0;
    end else if (srst_q) begin
      mon_q <= '0; // R06
      cmp_q <= '0;
      en_q <= '0;
    end else if (wr_go) begin
      if (wsel(awaddr_q, OFS_MON0_CTRL)) begin
        mon_q <= wdata_q[B_MON_DIR:B_MON_EN];
      end else if (awaddr_q == OFS_CMP0) begin
        cmp_q <= wdata_q[RES_W-1:0];
      end else if (wsel(awaddr_q, OFS_IRQ_EN)) begin
        en_q <= wdata_q[N_IRQ-1:0];
      end
    end
  end

  // Conversion clock setting survives soft reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_set_q <= CLK_SET_RST;
    end else if (wr_go && wsel(awaddr_q, OFS_CLK_SET)) begin
      clk_set_q <= wdata_q[3:0]; // R06
    end
  end
  assign conversion_clock_setting_out = clk_set_q;

  // ----------------------------------------------------------------
  // Pin synchronisers and trigger routing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_s_q <= '0;
      t5_s_q <= '0;
      t6_s_q <= '0;
      dn_s_q <= '0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], ext_trig_in};
      t5_s_q <= {t5_s_q[1:0], timer5_compare0_in};
      t6_s_q <= {t6_s_q[1:0], timer6_compare0_in};
      dn_s_q <= {dn_s_q[1:0], prio_conv_done_in};
    end
  end
  assign ext_r = ext_s_q[1] && !ext_s_q[2];
  assign t5_r = t5_s_q[1] && !t5_s_q[2];
  assign t6_r = t6_s_q[1] && !t6_s_q[2];
  assign dn_r = dn_s_q[1] && !dn_s_q[2];

  // Start pulses; events while disabled are simply dropped
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prio_hw_start_out <= 1'b0;
      norm_hw_start_out <= 1'b0;
    end else begin
      prio_hw_start_out <= trig_q.prio_en && (trig_q.prio_src ? t5_r : ext_r); // R01 R02 R14
      norm_hw_start_out <= trig_q.norm_en && (trig_q.norm_src ? t6_r : ext_r); // R03 R04 R14
    end
  end

  // Done flag: completion sets, a read of the control register clears; set wins
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_q <= 1'b0;
    end else if (dn_r) begin
      done_q <= 1'b1; // R13
    end else if (srst_q || (rd_go && s_axi_araddr == OFS_PRIO_CTRL)) begin
      done_q <= 1'b0; // R12
    end
  end

  atr_monitor #(.NRES(NRES)) u_mon (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .srst_in(srst_q),
    .cfg_in(mon_q),
    .norm_res_in(norm_res_in),
    .prio_res_in(prio_res_in),
    .cmp_in(cmp_q),
    .hit_out(mon_hit)
  );

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign ev[I_MON0] = mon_hit;
  assign ev[I_PRIO_DONE] = dn_r;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_q <= '0;
    end else if (srst_q) begin
      stat_q <= ev;
    end else if (wr_go && wsel(awaddr_q, OFS_IRQ_CLR)) begin
      stat_q <= (stat_q & ~wdata_q[N_IRQ-1:0]) | ev; // Set wins over clear
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  assign irq_out = |(stat_q & en_q);

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      if (s_axi_araddr == OFS_PRIO_CTRL) begin
        rdata_q[B_DONE] <= done_q; // R13
      end else if (s_axi_araddr == OFS_MON0_CTRL) begin
        rdata_q[B_MON_DIR:B_MON_EN] <= mon_q;
      end else if (s_axi_araddr == OFS_TRIG_RST) begin
        rdata_q[B_PRIO_SRC:B_NORM_EN] <= trig_q; // Key bits read as zero
      end else if (s_axi_araddr == OFS_CMP0) begin
        rdata_q[RES_W-1:0] <= cmp_q;
      end else if (s_axi_araddr == OFS_CLK_SET) begin
        rdata_q[3:0] <= clk_set_q;
      end else if (s_axi_araddr == OFS_IRQ_STAT) begin
        rdata_q[N_IRQ-1:0] <= stat_q;
      end else if (s_axi_araddr == OFS_IRQ_EN) begin
        rdata_q[N_IRQ-1:0] <= en_q;
      end else if (s_axi_araddr != OFS_IRQ_CLR) begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Key steps: an arm write, then a fire write
  sequence s_arm;
    wr_go && awaddr_q == OFS_TRIG_RST && wstrb0_q && wdata_q[1:0] == KEY_ARM;
  endsequence
  sequence s_fire;
    wr_go && awaddr_q == OFS_TRIG_RST && wstrb0_q && wdata_q[1:0] == KEY_FIRE;
  endsequence
  // Trigger routing
  a_src_held_one: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R08
    trig_q.prio_src && trig_q.norm_src) else $error("source bit left timer match");
  a_prio_gate_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R02
    !trig_q.prio_en |=> !prio_hw_start_out) else $error("priority start while disabled");
  a_norm_gate_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R04
    !trig_q.norm_en |=> !norm_hw_start_out) else $error("normal start while disabled");
  a_prio_t5_start: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R01
    trig_q.prio_en && t5_r |=> prio_hw_start_out) else $error("timer5 match lost");
  a_norm_t6_start: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R03
    trig_q.norm_en && t6_r |=> norm_hw_start_out) else $error("timer6 match lost");
  a_norm_no_pin: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R08
    ext_r && !t6_r |=> !norm_hw_start_out) else $error("pin edge started normal conversion");
  // Soft reset key
  a_key_arm: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R05
    s_arm |=> key_q == KEY_ARMED) else $error("arm write did not arm key");
  a_key_fire: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R05
    (key_q == KEY_ARMED) ##0 s_fire |=> srst_q) else $error("key sequence did not reset");
  a_key_needs_arm: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R05
    srst_q |-> $past(key_q) == KEY_ARMED) else $error("reset without armed key");
  a_srst_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R05
    srst_q |=> !srst_q) else $error("soft reset longer than one cycle");
  a_srst_clears: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R06
    srst_q |=> mon_q == '0 && !trig_q.prio_en && clk_set_q == $past(clk_set_q))
    else $error("soft reset result wrong");
  // Done flag and interrupt status
  a_done_read_clr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R12
    rd_go && s_axi_araddr == OFS_PRIO_CTRL && !dn_r |=> !done_q) else $error("done not cleared by read");
  a_done_set: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R13
    dn_r |=> done_q) else $error("done flag not set");
  a_stat_sticky: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    stat_q[I_MON0] && !srst_q && !(wr_go && wsel(awaddr_q, OFS_IRQ_CLR)) |=> stat_q[I_MON0])
    else $error("monitor status lost without clear");
  // Bus answers stand until taken
  a_bvalid_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
endmodule // atr_ctrl
`default_nettype wire

// ===== sim/atr_partner.sv
// Far-side model: timer compare matches and priority conversion completion
`timescale 1ns/1ps
`default_nettype none
module atr_partner (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [2:0] fire_in,
  output logic timer5_compare0_out,
  output logic timer6_compare0_out,
  output logic prio_conv_done_out
);
  logic [1:0] c5_q, c6_q, cd_q;
  // Each request holds its event line high for three cycles so a synchroniser sees one edge
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      c5_q <= 2'h0;
      c6_q <= 2'h0;
      cd_q <= 2'h0;
    end else begin
      c5_q <= fire_in[0] ? 2'h3 : ((c5_q != 2'h0) ? c5_q - 2'h1 : 2'h0);
      c6_q <= fire_in[1] ? 2'h3 : ((c6_q != 2'h0) ? c6_q - 2'h1 : 2'h0);
      cd_q <= fire_in[2] ? 2'h3 : ((cd_q != 2'h0) ? cd_q - 2'h1 : 2'h0);
    end
  end
  // Only timer matches start conversions; the shared pin is never used as a source
  assign timer5_compare0_out = (c5_q != 2'h0);
  assign timer6_compare0_out = (c6_q != 2'h0);
  assign prio_conv_done_out = (cd_q != 2'h0);
endmodule // atr_partner
`default_nettype wire

// ===== sim/test_atr_ctrl.sv
// Testbench of the converter trigger, soft reset and monitor control block
`timescale 1ns/1ps
`default_nettype none
module test_atr_ctrl;
  import atr_pkg::*;
  logic clk_sys_in = 1'h0;
  logic rstn_in = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp, wrsp;
  logic ext_trig = 1'h0;
  logic [2:0] fire = 3'h0;
  logic t5, t6, cdone, p_start, n_start, s_rst, irq;
  logic [79:0] norm_res = 80'h0;
  logic [9:0] prio_res = 10'h0;
  logic [3:0] clk_set;
  int err_total = 0, n_compared = 0, cnt_p = 0, cnt_n = 0, cnt_s = 0;
  // ----------------------------------------
  // Clock, instances and pulse counters
  // ----------------------------------------
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  atr_ctrl atr_ctrl_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trig_in(ext_trig), .timer5_compare0_in(t5), .timer6_compare0_in(t6),
    .prio_conv_done_in(cdone), .norm_res_in(norm_res), .prio_res_in(prio_res),
    .prio_hw_start_out(p_start), .norm_hw_start_out(n_start), .soft_reset_out(s_rst),
    .conversion_clock_setting_out(clk_set), .irq_out(irq));
  atr_partner atr_partner_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .fire_in(fire), .timer5_compare0_out(t5),
    .timer6_compare0_out(t6), .prio_conv_done_out(cdone));
  // One-cycle pulses are counted in the middle of each cycle
  always @(negedge clk_sys_in) begin
    if (p_start === 1'h1) cnt_p++;
    if (n_start === 1'h1) cnt_n++;
    if (s_rst === 1'h1) cnt_s++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Request, qualifiers and answer strobes change just after an edge and hold until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic at, dt;
    int n;
    at = 1'h0;
    dt = 1'h0;
    n = 0;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(at && dt) && n < 50) begin
      @(negedge clk_sys_in);
      at = at | (awvalid & awready);
      dt = dt | (wvalid & wready);
      @(posedge clk_sys_in);
      if (at) awvalid <= 1'h0;
      if (dt) wvalid <= 1'h0;
      n++;
    end
    while (n < 50 && bvalid !== 1'h1) begin
      @(negedge clk_sys_in);
      n++;
    end
    wrsp = bresp;
    @(posedge clk_sys_in);
    bready <= 1'h0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dv);
    logic at;
    int n;
    at = 1'h0;
    n = 0;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!at && n < 50) begin
      @(negedge clk_sys_in);
      at = arvalid & arready;
      @(posedge clk_sys_in);
      if (at) arvalid <= 1'h0;
      n++;
    end
    while (n < 50 && rvalid !== 1'h1) begin
      @(negedge clk_sys_in);
      n++;
    end
    dv = rdata;
    rsp = rresp;
    @(posedge clk_sys_in);
    rready <= 1'h0;
    tmo(n);
  endtask
  task automatic pulse(input logic [2:0] f);
    @(posedge clk_sys_in);
    fire <= f;
    @(posedge clk_sys_in);
    fire <= 3'h0;
    wt(10);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(OFS_TRIG_RST, d);
    chk("trig_rst_reset", d, 32'h000000a0);
    rd(OFS_MON0_CTRL, d);
    chk("mon0_reset", d, 32'h0);
    rd(8'h20, d);
    chk("unmapped_resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("unmapped_data", d, 32'h0);
    wr(8'h20, 32'h0);
    chk("unmapped_wresp", {30'h0, wrsp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_trig();
    int p0, n0;
    p0 = cnt_p;
    n0 = cnt_n;
    pulse(3'h3);
    wr(OFS_TRIG_RST, 32'h00000050);
    chk("mapped_wresp", {30'h0, wrsp}, {30'h0, RESP_OKAY});
    wt(10);
    chk("disabled_prio", cnt_p - p0, 0);
    chk("disabled_norm", cnt_n - n0, 0);
    rd(OFS_TRIG_RST, d);
    chk("src_zero_refused", d, 32'h000000f0);
    pulse(3'h1);
    chk("timer5_prio", cnt_p - p0, 1);
    chk("timer5_not_norm", cnt_n - n0, 0);
    pulse(3'h2);
    chk("timer6_norm", cnt_n - n0, 1);
    chk("timer6_not_prio", cnt_p - p0, 1);
    @(posedge clk_sys_in);
    ext_trig <= 1'h1;
    wt(5);
    ext_trig <= 1'h0;
    wt(5);
    chk("pin_ignored", cnt_p + cnt_n - p0 - n0, 2);
    $display("test triggers done");
  endtask
  task automatic t_soft();
    int s0;
    s0 = cnt_s;
    wr(OFS_CLK_SET, 32'h5);
    wr(OFS_MON0_CTRL, 32'h00000021);
    wr(OFS_TRIG_RST, 32'h00000051);
    wt(3);
    chk("fire_without_arm", cnt_s - s0, 0);
    wr(OFS_TRIG_RST, 32'h00000052);
    wr(OFS_TRIG_RST, 32'h00000051);
    wt(3);
    chk("soft_reset_pulse", cnt_s - s0, 1);
    rd(OFS_MON0_CTRL, d);
    chk("mon0_cleared", d, 32'h0);
    rd(OFS_TRIG_RST, d);
    chk("trig_cleared", d, 32'h000000a0);
    rd(OFS_CLK_SET, d);
    chk("clock_kept", d, 32'h5);
    chk("clock_out_kept", {28'h0, clk_set}, 32'h5);
    $display("test soft reset done");
  endtask
  task automatic t_mon();
    // Slot 3 holds a low value, every other slot the top value
    norm_res <= {10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h050, 10'h3ff, 10'h3ff, 10'h3ff};
    prio_res <= 10'h200;
    wr(OFS_CMP0, 32'h00000100);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_MON0_CTRL, 32'h00000011);
    wt(4);
    chk("prio_not_below", {31'h0, irq}, 32'h0);
    wr(OFS_MON0_CTRL, 32'h00000007);
    wt(4);
    chk("slot3_below_irq", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, d);
    chk("status_hit", d & 32'h1, 32'h1);
    wr(OFS_MON0_CTRL, 32'h00000006);
    wr(OFS_IRQ_CLR, 32'h1);
    wt(4);
    chk("disabled_no_irq", {31'h0, irq}, 32'h0);
    wr(OFS_MON0_CTRL, 32'h00000031);
    wt(4);
    chk("prio_above_irq", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    wt(2);
    chk("masked_irq", {31'h0, irq}, 32'h0);
    wr(OFS_MON0_CTRL, 32'h0);
    wr(OFS_IRQ_CLR, 32'h1);
    $display("test monitor done");
  endtask
  task automatic t_done();
    rd(OFS_PRIO_CTRL, d);
    chk("done_before", d & 32'h80, 32'h0);
    pulse(3'h4);
    rd(OFS_PRIO_CTRL, d);
    chk("done_set", d & 32'h80, 32'h80);
    rd(OFS_PRIO_CTRL, d);
    chk("done_read_clear", d & 32'h80, 32'h0);
    rd(OFS_IRQ_STAT, d);
    chk("status_done", d & 32'h2, 32'h2);
    wr(OFS_IRQ_EN, 32'h2);
    chk("done_irq", {31'h0, irq}, 32'h1);
    $display("test done flag done");
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    t_reset();
    t_trig();
    t_soft();
    t_mon();
    t_done();
    end_of_test();
  end
endmodule // test_atr_ctrl
`default_nettype wire
